/* agw_regs.svh */
// Purpose: Register indices, field positions, reset values and timing counts
// Assumes: APB byte address is four times the register index
// Notes: Indices are eight bits wide; the APB address carries them in bits 9:2
`ifndef AGW_REGS_SVH
`define AGW_REGS_SVH

`define AGW_IDX_CFG 8'hbc
`define AGW_IDX_CTL 8'he8
`define AGW_IDX_RES_LO 8'hbd
`define AGW_IDX_RES_HI 8'hbe
`define AGW_IDX_TRACK 8'hba
`define AGW_IDX_GTL 8'hc3
`define AGW_IDX_GTH 8'hc4
`define AGW_IDX_LTL 8'hc5
`define AGW_IDX_LTH 8'hc6
`define AGW_IDX_REF 8'hd1
`define AGW_IDX_IRQ_ST 8'hf0
`define AGW_IDX_IRQ_MASK 8'hf1

`define AGW_GAIN_ADDR_HI 8'h04
`define AGW_GAIN_ADDR_LO 8'h07
`define AGW_GAIN_ADDR_ADD 8'h08

`define AGW_CFG_GAIN_ACC 0
`define AGW_CTL_EN 7
`define AGW_CTL_BURST 6
`define AGW_CTL_START 4
`define AGW_CTL_WIN 3
`define AGW_IRQ_DONE 0
`define AGW_IRQ_WIN 1

`define AGW_RST_CFG 8'hf8
`define AGW_RST_TRACK 8'hff
`define AGW_RST_REF 6'h00
`define AGW_RST_GT 16'hffff
`define AGW_RST_LT 16'h0000

`define AGW_CLK_MHZ 25
`define AGW_PWR_STEP_NS 200
`define AGW_PWR_STEP_CYC ((`AGW_PWR_STEP_NS * `AGW_CLK_MHZ + 999) / 1000)
`define AGW_POST_CORE_CYC 2

`endif

/* agw_pkg.sv */
// Purpose: Types shared by the converter control block
// Assumes: Nothing beyond SystemVerilog packed types
// Notes: Enum order gives the documented two-bit tracking codes
package agw_pkg;

   typedef enum logic [2:0] {ST_IDLE, ST_POWERUP, ST_TRACK, ST_HOLD, ST_CONV} agw_fsm_type;

   typedef enum logic [1:0] {TRK_RESERVED, TRK_POST, TRK_PRE, TRK_DUAL} agw_trk_type;

   typedef struct packed {
      logic powered;
      logic low_power;
      logic tracking;
      logic conv_go;
      agw_trk_type mode;
   } agw_ana_type;

   typedef struct packed {
      logic ztc_bias_on;
      logic level_high;
      logic vdd_ref;
      logic temp_on;
      logic bias_on;
      logic buf_on;
   } agw_ref_type;

   typedef struct packed {
      logic [11:0] gain;
      logic gain_add;
   } agw_gain_type;

endpackage

/* agw_tick_div.sv */
// Purpose: Converter clock as a one-cycle enable from the core clock
// Assumes: Divide ratio is i_div plus one
// Notes: i_clear restarts the phase so tracking starts on a clean edge
`timescale 1ns/10ps
module agw_tick_div (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_clear,
   input wire logic [4:0] i_div,
   output logic o_tick
);
   typedef struct packed {
      logic [4:0] cnt;
      logic tick;
   } agw_div_type;

   agw_div_type s_r;
   agw_div_type s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      if (i_clear) begin
         s_nxt.cnt = 5'h00;
      end else if (s_r.cnt >= i_div) begin
         s_nxt.cnt = 5'h00;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.cnt = s_r.cnt + 5'h01;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_tick = s_r.tick;
endmodule

/* agw_win_cmp.sv */
// Purpose: Window detector decision for one conversion result
// Assumes: Limits and result are right-justified 16-bit values
// Notes: Limit order picks inside or outside detection
`timescale 1ns/10ps
module agw_win_cmp (
   input wire logic [15:0] i_result,
   input wire logic [15:0] i_gt,
   input wire logic [15:0] i_lt,
   output logic o_hit
);
   logic above;
   logic below;

   assign above = i_result > i_gt;
   assign below = i_result < i_lt;
   // Less-than above greater-than means inside, otherwise outside
   assign o_hit = (i_lt > i_gt) ? (above && below) : (above || below);
endmodule

/* agw_ctrl.sv */
// Purpose: Converter control: gain access, burst power-up, tracking, window detector, reference bits
// Assumes: APB slave, zero wait states; conversion datapath outside answers with i_conv_done
// Notes: Read data is captured in the setup phase and shown in the access phase
//        Starts while busy, or with neither enable nor burst set, are dropped
//        Gain registers have no read path; result reads show the last result
//        Flag and status bits set by an event win over a clear in that cycle
// Notes on behaviour
// - Gain-access set turns result high/low writes into gain address/data writes.
// - Three gain registers are write-only; result reads never return them.
// - Gain address 04 upper eight bits, 07 low nibble, 08 gain-add bit.
// - Burst with enable clear waits (power field plus one) times 200 ns.
// - Power follows enable; burst keeps on, or sleeps and wakes per start.
// - Tracking field: 01 post, 10 pre, 11 dual tracking; 00 reserved.
// - Post-track 00 is two converter clocks, 01 four, plus two core clocks.
// - Each result is compared with the limits; a hit sets the window flag.
// - Limit order decides inside or outside detection.
// - Window flag readable for polling and also an interrupt source.
// - Zero-TC bias bit clear switches that bias on whenever needed.
// - Reference bit 4 selects the internal reference level, 1 is 2.20 V.
// - Reference bits 7:6 read zero and ignore writes.
// - Reference bit 2 switches the temperature sensor.
// - Reference bit 0 enables the reference buffer driving the reference pin.
//
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
`include "agw_regs.svh"
module agw_ctrl (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_conv_start,
   input wire logic i_conv_done,
   input wire logic [11:0] i_conv_data,
   output agw_pkg::agw_ana_type o_ana,
   output agw_pkg::agw_ref_type o_ref,
   output agw_pkg::agw_gain_type o_gain,
   output logic o_irq
);
   import agw_pkg::*;

   typedef struct packed {
      logic [7:0] cfg;
      logic en;
      logic burst;
      logic win_flag;
      logic [7:0] trk;
      logic [5:0] refc;
      logic [7:0] gain_addr;
      logic [7:0] gain_hi;
      logic [3:0] gain_lo;
      logic gain_add;
      logic [15:0] result;
      logic [15:0] gt;
      logic [15:0] lt;
      logic [1:0] irq_st;
      logic [1:0] irq_mask;
      agw_fsm_type fsm;
      logic [6:0] cnt;
      logic go;
      logic [31:0] prdata;
      logic slverr;
   } agw_state_type;

   agw_state_type s_r;
   agw_state_type s_nxt;

   logic sar_tick;
   logic win_hit;
   logic setup;
   logic wr;
   logic hit;
   logic [7:0] idx;
   logic [7:0] rd;
   logic start;
   logic [6:0] post_ticks;
   logic powered;
   logic wr_hit;
   logic start_ok;
   logic done_ok;
   logic pre_trk;
   logic wake;
   logic busy;
   logic bias_need;

   assign setup = i_psel && !i_penable;
   assign wr = i_psel && i_penable && i_pwrite;
   assign idx = i_paddr[9:2];

   assign pre_trk = s_r.trk[3:2] == 2'b10;
   assign wake = s_r.burst && !s_r.en;
   assign busy = s_r.fsm != ST_IDLE;
   // Done outside a conversion is a stray pulse and is ignored
   assign done_ok = s_r.fsm == ST_CONV && i_conv_done;

   agw_tick_div u_div (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_clear(s_r.fsm != ST_TRACK),
      .i_div(s_r.cfg[7:3]),
      .o_tick(sar_tick)
   );

   agw_win_cmp u_win (
      .i_result({4'h0, i_conv_data}),
      .i_gt(s_r.gt),
      .i_lt(s_r.lt),
      .o_hit(win_hit)
   );

   // Converter clocks for each post-track code; upper codes double again
   always_comb begin
      case (s_r.trk[1:0])
         2'b00: post_ticks = 7'h02;
         2'b01: post_ticks = 7'h04;
         2'b10: post_ticks = 7'h08;
         default: post_ticks = 7'h10;
      endcase
   end

   // Address decode and read mux; the gain registers have no read path
   always_comb begin
      hit = 1'b1;
      rd = 8'h00;
      if (i_paddr[11:10] != 2'b00 || i_paddr[1:0] != 2'b00) begin
         hit = 1'b0;
      end else if (idx == `AGW_IDX_CFG) begin
         rd = s_r.cfg;
      end else if (idx == `AGW_IDX_CTL) begin
         rd = {s_r.en, s_r.burst, 1'b0, busy, s_r.win_flag, 3'h0};
      end else if (idx == `AGW_IDX_RES_LO) begin
         rd = s_r.result[7:0];
      end else if (idx == `AGW_IDX_RES_HI) begin
         rd = s_r.result[15:8];
      end else if (idx == `AGW_IDX_TRACK) begin
         rd = s_r.trk;
      end else if (idx == `AGW_IDX_GTL) begin
         rd = s_r.gt[7:0];
      end else if (idx == `AGW_IDX_GTH) begin
         rd = s_r.gt[15:8];
      end else if (idx == `AGW_IDX_LTL) begin
         rd = s_r.lt[7:0];
      end else if (idx == `AGW_IDX_LTH) begin
         rd = s_r.lt[15:8];
      end else if (idx == `AGW_IDX_REF) begin
         rd = {2'b00, s_r.refc};
      end else if (idx == `AGW_IDX_IRQ_ST) begin
         rd = {6'h00, s_r.irq_st};
      end else if (idx == `AGW_IDX_IRQ_MASK) begin
         rd = {6'h00, s_r.irq_mask};
      end else begin
         hit = 1'b0;
      end
   end

   assign wr_hit = wr && hit;
   assign start = i_conv_start || (wr_hit && idx == `AGW_IDX_CTL && i_pwdata[`AGW_CTL_START]);

   // Starts are not queued: one that meets a busy sequencer, or neither enable nor burst set, is lost
   always_comb begin
      start_ok = 1'b0;
      if (start && !busy) begin
         if (s_r.en || s_r.burst) begin
            start_ok = 1'b1;
         end
      end
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.go = 1'b0;
      // Capture at setup so the access phase shows a word that cannot move
      if (setup) begin
         s_nxt.prdata = {24'h000000, rd};
         s_nxt.slverr = !hit;
      end
      if (wr_hit) begin
         if (idx == `AGW_IDX_CFG) begin
            s_nxt.cfg = i_pwdata[7:0];
         end else if (idx == `AGW_IDX_CTL) begin
            s_nxt.en = i_pwdata[`AGW_CTL_EN];
            s_nxt.burst = i_pwdata[`AGW_CTL_BURST];
            if (!i_pwdata[`AGW_CTL_WIN]) begin
               s_nxt.win_flag = 1'b0;
            end
         end else if (idx == `AGW_IDX_RES_HI) begin
            if (s_r.cfg[`AGW_CFG_GAIN_ACC]) begin
               s_nxt.gain_addr = i_pwdata[7:0];
            end
         end else if (idx == `AGW_IDX_RES_LO) begin
            // Without gain access the result bytes are read-only
            if (s_r.cfg[`AGW_CFG_GAIN_ACC]) begin
               if (s_r.gain_addr == `AGW_GAIN_ADDR_HI) begin
                  s_nxt.gain_hi = i_pwdata[7:0];
               end else if (s_r.gain_addr == `AGW_GAIN_ADDR_LO) begin
                  s_nxt.gain_lo = i_pwdata[7:4];
               end else if (s_r.gain_addr == `AGW_GAIN_ADDR_ADD) begin
                  s_nxt.gain_add = i_pwdata[0];
               end
            end
         end else if (idx == `AGW_IDX_TRACK) begin
            s_nxt.trk = i_pwdata[7:0];
         end else if (idx == `AGW_IDX_GTL) begin
            s_nxt.gt[7:0] = i_pwdata[7:0];
         end else if (idx == `AGW_IDX_GTH) begin
            s_nxt.gt[15:8] = i_pwdata[7:0];
         end else if (idx == `AGW_IDX_LTL) begin
            s_nxt.lt[7:0] = i_pwdata[7:0];
         end else if (idx == `AGW_IDX_LTH) begin
            s_nxt.lt[15:8] = i_pwdata[7:0];
         end else if (idx == `AGW_IDX_REF) begin
            s_nxt.refc = i_pwdata[5:0];
         end else if (idx == `AGW_IDX_IRQ_ST) begin
            s_nxt.irq_st = s_r.irq_st & ~i_pwdata[1:0];
         end else if (idx == `AGW_IDX_IRQ_MASK) begin
            s_nxt.irq_mask = i_pwdata[1:0];
         end
      end

      // Conversion sequencer; starts while busy are dropped
      case (s_r.fsm)
         ST_IDLE: begin
            if (start_ok) begin
               if (wake) begin
                  // Count is reloaded on every wake, so each burst start pays the full wait
                  s_nxt.fsm = ST_POWERUP;
                  s_nxt.cnt = 7'((s_r.trk[7:4] + 5'h01) * `AGW_PWR_STEP_CYC);
               end else if (pre_trk) begin
                  s_nxt.fsm = ST_CONV;
                  s_nxt.go = 1'b1;
               end else begin
                  s_nxt.fsm = ST_TRACK;
                  s_nxt.cnt = post_ticks;
               end
            end
         end
         ST_POWERUP: begin
            if (s_r.cnt <= 7'h01) begin
               if (pre_trk) begin
                  s_nxt.fsm = ST_CONV;
                  s_nxt.go = 1'b1;
               end else begin
                  s_nxt.fsm = ST_TRACK;
                  s_nxt.cnt = post_ticks;
               end
            end else begin
               s_nxt.cnt = s_r.cnt - 7'h01;
            end
         end
         ST_TRACK: begin
            if (sar_tick) begin
               if (s_r.cnt <= 7'h01) begin
                  s_nxt.fsm = ST_HOLD;
                  s_nxt.cnt = 7'(`AGW_POST_CORE_CYC);
               end else begin
                  s_nxt.cnt = s_r.cnt - 7'h01;
               end
            end
         end
         ST_HOLD: begin
            if (s_r.cnt <= 7'h01) begin
               s_nxt.fsm = ST_CONV;
               s_nxt.go = 1'b1;
            end else begin
               s_nxt.cnt = s_r.cnt - 7'h01;
            end
         end
         ST_CONV: begin
            if (done_ok) begin
               s_nxt.fsm = ST_IDLE;
            end
         end
         default: begin
            s_nxt.fsm = ST_IDLE;
         end
      endcase

      // Completion events win over a clear in the same cycle
      if (done_ok) begin
         s_nxt.result = {4'h0, i_conv_data};
         s_nxt.irq_st[`AGW_IRQ_DONE] = 1'b1;
         if (win_hit) begin
            s_nxt.win_flag = 1'b1;
            s_nxt.irq_st[`AGW_IRQ_WIN] = 1'b1;
         end
      end
   end

   // Fields without a documented reset value clear to zero
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         s_r <= '0;
         s_r.cfg <= `AGW_RST_CFG;
         s_r.trk <= `AGW_RST_TRACK;
         s_r.refc <= `AGW_RST_REF;
         s_r.gt <= `AGW_RST_GT;
         s_r.lt <= `AGW_RST_LT;
         s_r.fsm <= ST_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Power is asserted for the whole burst wake, not only the conversion
   assign powered = s_r.burst ? (s_r.en || busy) : s_r.en;

   always_comb begin
      o_ana.powered = powered;
      o_ana.low_power = wake && !busy;
      o_ana.tracking = s_r.fsm == ST_TRACK || s_r.fsm == ST_HOLD ||
                       (s_r.fsm == ST_IDLE && powered && s_r.trk[3]);
      o_ana.conv_go = s_r.go;
      o_ana.mode = agw_trk_type'(s_r.trk[3:2]);
   end

   // Any analog user keeps the zero-TC bias up; software can also pin it on
   always_comb begin
      bias_need = powered;
      if (s_r.refc[2] || s_r.refc[1] || s_r.refc[0]) begin
         bias_need = 1'b1;
      end
   end

   always_comb begin
      o_ref.ztc_bias_on = s_r.refc[5] || bias_need;
      o_ref.level_high = s_r.refc[4];
      o_ref.vdd_ref = s_r.refc[3];
      o_ref.temp_on = s_r.refc[2];
      o_ref.bias_on = s_r.refc[1];
      o_ref.buf_on = s_r.refc[0];
   end

   assign o_gain.gain = {s_r.gain_hi, s_r.gain_lo};
   assign o_gain.gain_add = s_r.gain_add;
   assign o_irq = |(s_r.irq_st & s_r.irq_mask);
   assign o_prdata = s_r.prdata;
   // No wait states: every register answers in its access cycle
   assign o_pready = 1'b1;
   assign o_pslverr = i_psel && i_penable && s_r.slverr;
endmodule

/* agw_ctrl_assertions.sv */
// Purpose: Port checks for the converter control block
// Assumes: Register index sits in paddr bits 9:2
// Notes: Watches inputs and outputs; drives nothing
`timescale 1ns/10ps
`include "agw_regs.svh"
module agw_ctrl_assertions (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic i_conv_start,
   input wire logic i_conv_done,
   input wire logic [11:0] i_conv_data,
   input wire agw_pkg::agw_ana_type o_ana,
   input wire agw_pkg::agw_ref_type o_ref,
   input wire agw_pkg::agw_gain_type o_gain,
   input wire logic o_irq
);
   import agw_pkg::*;
   logic wr;
   assign wr = i_psel && i_penable && i_pwrite;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   gain_write_only_a: assert property ($changed(o_gain) && $past(i_rstn) |->
      $past(wr && i_paddr[9:2] == `AGW_IDX_RES_LO)) else $error("gain moved without data write");
   ref_bits_held_a: assert property ($changed({o_ref.level_high, o_ref.temp_on, o_ref.buf_on})
      && $past(i_rstn) |-> $past(wr && i_paddr[9:2] == `AGW_IDX_REF)) else $error("reference bit moved");
   mode_from_reg_a: assert property ($changed(o_ana.mode) && $past(i_rstn) |->
      $past(wr && i_paddr[9:2] == `AGW_IDX_TRACK)) else $error("tracking mode moved");
   go_one_cycle_a: assert property (o_ana.conv_go |=> !o_ana.conv_go)
      else $error("convert pulse too long");
   irq_cause_a: assert property ($rose(o_irq) |-> $past(i_conv_done || wr))
      else $error("interrupt without cause");
   irq_sticky_a: assert property (o_irq && !wr |=> o_irq)
      else $error("interrupt dropped without write");
   read_upper_zero_a: assert property (i_psel && i_penable |-> o_pready && o_prdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   err_in_access_a: assert property (o_pslverr |-> i_psel && i_penable)
      else $error("error outside access phase");
   go_c: cover property (o_ana.conv_go);
   irq_c: cover property ($rose(o_irq));
   gain_c: cover property ($changed(o_gain));
endmodule
bind agw_ctrl agw_ctrl_assertions chk_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(i_psel),
   .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .i_conv_start(i_conv_start), .i_conv_done(i_conv_done),
   .i_conv_data(i_conv_data), .o_ana(o_ana), .o_ref(o_ref), .o_gain(o_gain), .o_irq(o_irq));

/* tb_adc_gain_track_window_ctrl.sv */
// Purpose: Self-checking bench for the converter control block
// Assumes: Zero wait APB, converter done driven by the bench
// Notes: Latencies compared as differences, so fixed offsets cancel
`timescale 1ns/10ps
`include "agw_regs.svh"
module tb_adc_gain_track_window_ctrl;
   import agw_pkg::*;
   logic i_clk = 0;
   logic i_rstn = 0;
   logic psel = 0;
   logic pen = 0;
   logic pwr = 0;
   logic cstart = 0;
   logic cdone = 0;
   logic [11:0] paddr = 0;
   logic [11:0] cdata = 0;
   logic [31:0] pwdata = 0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready, pslverr, irq, err;
   agw_ana_type ana;
   agw_ref_type rf;
   agw_gain_type gn;
   int fails = 0;
   int tests_run = 0;
   int cyc = 0;
   int lat;
   always #20 i_clk = ~i_clk;
   agw_ctrl dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_conv_start(cstart), .i_conv_done(cdone), .i_conv_data(cdata), .o_ana(ana), .o_ref(rf),
      .o_gain(gn), .o_irq(irq));
   task test_done;
      if (fails == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("Error %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      @(posedge i_clk);
      psel <= 1;
      pen <= 0;
      pwr <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge i_clk);
      pen <= 1;
      @(posedge i_clk);
      while (pready !== 1'b1) @(posedge i_clk);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      pen <= 0;
      #1;
   endtask
   task wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1, idx, d);
   endtask
   task rdc(input logic [7:0] idx, input logic [7:0] e);
      apb(0, idx, 8'h00);
      chk(rd, {24'h0, e});
   endtask
   // Latency counted in falling edges from the start pulse
   task conv_end(input logic [11:0] d);
      lat = 0;
      @(negedge i_clk);
      while (ana.conv_go !== 1'b1) begin
         lat++;
         @(negedge i_clk);
      end
      @(posedge i_clk);
      cdone <= 1;
      cdata <= d;
      @(posedge i_clk);
      cdone <= 0;
      repeat (3) @(posedge i_clk);
   endtask
   task conv(input logic [11:0] d);
      @(posedge i_clk);
      cstart <= 1;
      @(posedge i_clk);
      cstart <= 0;
      conv_end(d);
   endtask
   // Software start through the control register, keeping the window flag
   task conv_sw(input logic [11:0] d);
      wr(`AGW_IDX_CTL, 8'h98);
      conv_end(d);
   endtask
   task t_reset;
      rdc(`AGW_IDX_TRACK, 8'hff);
      rdc(`AGW_IDX_REF, 8'h00);
      rdc(`AGW_IDX_CFG, 8'hf8);
      chk(ana.mode, 2'b11);
      chk(gn, 0);
      apb(0, 8'h00, 8'h00);
      chk({rd[7:0], err}, 9'h001);
   endtask
   task t_ref;
      wr(`AGW_IDX_REF, 8'hff);
      rdc(`AGW_IDX_REF, 8'h3f);
      chk({rf.level_high, rf.temp_on, rf.buf_on}, 3'h7);
      chk({rf.ztc_bias_on, rf.vdd_ref, rf.bias_on}, 3'h7);
      wr(`AGW_IDX_REF, 8'hc0);
      rdc(`AGW_IDX_REF, 8'h00);
      chk({rf.level_high, rf.temp_on, rf.buf_on}, 3'h0);
      chk({rf.ztc_bias_on, rf.vdd_ref, rf.bias_on}, 3'h0);
   endtask
   task t_track;
      for (int m = 0; m < 4; m++) begin
         wr(`AGW_IDX_TRACK, {4'h5, m[1:0], 2'b10});
         rdc(`AGW_IDX_TRACK, {4'h5, m[1:0], 2'b10});
         chk(ana.mode, m);
      end
   endtask
   task t_gain;
      wr(`AGW_IDX_CFG, 8'h01);
      wr(`AGW_IDX_RES_HI, `AGW_GAIN_ADDR_HI);
      wr(`AGW_IDX_RES_LO, 8'h6c);
      wr(`AGW_IDX_RES_HI, `AGW_GAIN_ADDR_LO);
      wr(`AGW_IDX_RES_LO, 8'ha5);
      wr(`AGW_IDX_RES_HI, `AGW_GAIN_ADDR_ADD);
      wr(`AGW_IDX_RES_LO, 8'h01);
      chk(gn, {12'h6ca, 1'b1});
      rdc(`AGW_IDX_RES_LO, 8'h00);
      wr(`AGW_IDX_CFG, 8'h00);
      wr(`AGW_IDX_RES_HI, `AGW_GAIN_ADDR_HI);
      wr(`AGW_IDX_RES_LO, 8'h11);
      chk(gn, {12'h6ca, 1'b1});
   endtask
   // Power-up step is 200 ns, five clocks at 25 MHz
   task t_burst;
      int l0;
      wr(`AGW_IDX_CTL, 8'h40);
      chk({ana.powered, ana.low_power}, 2'b01);
      wr(`AGW_IDX_TRACK, 8'h08);
      conv(12'h000);
      l0 = lat;
      wr(`AGW_IDX_TRACK, 8'h38);
      conv(12'h000);
      chk(lat - l0, 3 * (200 / 40));
      wr(`AGW_IDX_CTL, 8'hc0);
      chk({ana.powered, ana.low_power, rf.ztc_bias_on}, 3'b101);
      wr(`AGW_IDX_CTL, 8'h00);
      chk(ana.powered, 0);
      wr(`AGW_IDX_CTL, 8'h80);
      chk(ana.powered, 1);
      chk(ana.tracking, 1);
   endtask
   // Divider 1 gives one converter tick every two clocks
   task t_post;
      int l0;
      int tk[4] = '{2, 4, 8, 16};
      wr(`AGW_IDX_CFG, 8'h08);
      for (int k = 0; k < 4; k++) begin
         wr(`AGW_IDX_TRACK, {6'h01, k[1:0]});
         chk(ana.tracking, 0);
         conv(12'h000);
         if (k == 0)
            l0 = lat;
         else
            chk(lat - l0, (tk[k] - 2) * 2);
      end
   endtask
   task t_win;
      wr(`AGW_IDX_GTL, 8'h00);
      wr(`AGW_IDX_GTH, 8'h01);
      wr(`AGW_IDX_LTL, 8'h00);
      wr(`AGW_IDX_LTH, 8'h02);
      wr(`AGW_IDX_IRQ_MASK, 8'h02);
      conv(12'h180);
      rdc(`AGW_IDX_CTL, 8'h88);
      chk(irq, 1);
      conv(12'h080);
      rdc(`AGW_IDX_CTL, 8'h88);
      rdc(`AGW_IDX_RES_LO, 8'h80);
      wr(`AGW_IDX_CTL, 8'h80);
      wr(`AGW_IDX_IRQ_ST, 8'h03);
      rdc(`AGW_IDX_CTL, 8'h80);
      chk(irq, 0);
      wr(`AGW_IDX_GTH, 8'h02);
      wr(`AGW_IDX_LTH, 8'h01);
      conv(12'h180);
      rdc(`AGW_IDX_CTL, 8'h80);
      conv_sw(12'h080);
      rdc(`AGW_IDX_CTL, 8'h88);
      rdc(`AGW_IDX_IRQ_ST, 8'h03);
      wr(`AGW_IDX_IRQ_MASK, 8'h00);
      chk(irq, 0);
   endtask
   initial begin
      repeat (3) @(posedge i_clk);
      i_rstn <= 1;
      t_reset;
      t_ref;
      t_track;
      t_gain;
      t_burst;
      t_post;
      t_win;
      test_done;
   end
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         test_done;
      end
   end
endmodule
